// file: logic/status_fifo.sv
/*
 * Small queue of transfer status entries.
 * Refuses pushes itself while full; the caller need not.
 */
`timescale 1ns/1ps
module status_fifo
    import usb_sie_pkg::*;
#(
    parameter int DEPTH = STATUS_DEPTH,
    parameter int W = ENTRY_W
) (
    input wire logic pclk,
    input wire logic presetn,
    status_fifo_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH]; // Entry storage
    logic [AW-1:0] rd_ff; // Read pointer
    logic [AW-1:0] wr_ff; // Write pointer
    logic [AW:0] cnt_ff; // Entries held
    wire do_push = q.push && !q.full;
    wire do_pop = q.pop && !q.empty;
    assign q.head = mem_ff[rd_ff];
    assign q.empty = (cnt_ff == '0);
    assign q.full = (cnt_ff == (AW+1)'(DEPTH));
    // ------------------------------------------------------------
    // Pointers and count
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else if (q.flush) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (do_push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (do_pop) rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
    // Storage has no reset; contents are only trusted while counted
    always_ff @(posedge pclk) begin
        if (do_push) mem_ff[wr_ff] <= q.push_data;
    end
endmodule

// file: logic/status_fifo_if.sv
/*
 * Carrier between the top block and its transfer status queue.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ps
interface status_fifo_if #(parameter int W = 6) ();
    logic push; // Engine finished with a buffer
    logic [W-1:0] push_data; // Endpoint, direction, buffer parity
    logic pop; // Advance to next entry
    logic flush; // Drop all entries
    logic [W-1:0] head; // Oldest entry
    logic empty;
    logic full;
    modport queue (input push, push_data, pop, flush, output head, empty, full);
    modport user (output push, push_data, pop, flush, input head, empty, full);
endinterface

// file: logic/usb_sie_config_xcvr_status.sv
/*
 * Line configuration, external transceiver interface and transfer
 * status window of a USB serial engine, reached over APB.
 * Assumes the serial engine core sits on pclk, presents its driven
 * bus state and its buffer completion events, and that transceiver
 * pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
// Behaviour
// - External select bypasses internal transceiver
// - Driver pair encodes SE0, diff 0, diff 1
// - Sense pair decodes SE0, LS, FS, error
// - Transmit enable low while sending, else high
// - Monitor active by bit or external select
// - Pull-up on D+ full speed, D- low
// - Pull-up bit ignored with external transceiver
// - Ping-pong arrangement from two-bit field
// - Eye test repeats J-K or K-J endlessly
// - Status window shows head of four-entry queue
// - Clearing done flag pops; reflag within three cycles
// - Queue full endpoint request gets automatic NAK
// - Endpoint 6:3, direction 2, parity 1
// - Parity bit only for paired buffer endpoints
// - Module enable gates transmit, pull-ups, queue and NAK; not the receive path
module usb_sie_config_xcvr_status
    import usb_sie_pkg::*;
#(
    parameter int EYE_BIT_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_active,
    input wire logic [1:0] tx_line,
    input wire logic xfer_done,
    input wire logic [3:0] xfer_endpoint,
    input wire logic xfer_dir_in,
    input wire logic xfer_odd,
    input wire logic endpoint_request,
    output logic auto_nak,
    output logic [1:0] rx_line_state,
    output logic rx_data,
    output logic drive_plus_out,
    output logic drive_minus_out,
    output logic transmit_enable_n,
    input wire logic sense_plus_in,
    input wire logic sense_minus_in,
    input wire logic diff_receive_in,
    output logic int_drive_plus,
    output logic int_drive_minus,
    output logic int_transmit_enable_n,
    input wire logic int_sense_plus,
    input wire logic int_sense_minus,
    input wire logic int_receive,
    output logic oe_monitor_n,
    output logic dplus_pullup_en,
    output logic dminus_pullup_en,
    output logic full_speed_edges,
    output logic [1:0] pingpong_mode,
    output logic module_enabled
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] cfg_ff; // Line configuration
    logic [7:0] ctl_ff; // Control, module enable
    logic xfer_done_flag_ff; // Transfer done flag
    logic [1:0] reflag_cnt_ff; // Hold-off after a pop
    logic [2:0] sync1_ff; // First synchroniser stage
    logic [2:0] sync2_ff; // Second synchroniser stage
    logic drive_plus_ff;
    logic drive_minus_ff;
    logic tx_en_n_ff;
    logic mon_n_ff;
    logic dp_pu_ff;
    logic dm_pu_ff;
    logic auto_nak_ff;
    logic [31:0] prdata_ff;
    logic [7:0] eye_cnt_ff; // Bit period counter
    typedef enum {EYE_OFF, EYE_FIRST, EYE_SECOND} eye_state_t;
    eye_state_t eye_ff;
    eye_state_t nxt_eye;
    status_fifo_if #(.W(ENTRY_W)) sq ();
    // ------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------
    wire enabled = ctl_ff[CTL_MODULE_ENABLE];
    wire ext_sel = cfg_ff[CFG_EXT_XCVR];
    wire fs_sel = cfg_ff[CFG_FULL_SPEED];
    wire pull_req = cfg_ff[CFG_PULLUP];
    wire eye_req = cfg_ff[CFG_EYE_TEST] && enabled;
    wire [1:0] pp_field = cfg_ff[CFG_PP_HI:CFG_PP_LO];
    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire access = psel && penable;
    wire hit_cfg = (paddr == OFS_LINE_CONFIG);
    wire hit_st = (paddr == OFS_XFER_STATUS);
    wire hit_ctl = (paddr == OFS_USB_CONTROL);
    wire hit_flg = (paddr == OFS_USB_FLAGS);
    wire mapped = hit_cfg || hit_st || hit_ctl || hit_flg;
    wire wr_cfg = access && pwrite && hit_cfg;
    wire wr_ctl = access && pwrite && hit_ctl;
    wire rd_now = psel && !penable && !pwrite;
    // Flag is cleared by writing one while it is set
    wire done_clear = access && pwrite && hit_flg && pwdata[FLG_XFER_DONE];
    wire do_pop = done_clear && xfer_done_flag_ff;
    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_ff;
    // ------------------------------------------------------------
    // Status entry and its read view
    // ------------------------------------------------------------
    wire [3:0] head_ep = sq.head[5:2];
    wire head_in = sq.head[1];
    wire head_odd = sq.head[0];
    wire ep0 = (head_ep == 4'h0);
    // Which endpoints really own an even and an odd descriptor
    wire paired = (pp_field == PP_EP0_OUT) ? (ep0 && !head_in) :
        (pp_field == PP_ALL) ? 1'b1 :
        (pp_field == PP_ALL_BUT_EP0) ? !ep0 : 1'b0;
    wire [7:0] status_view = {1'b0, head_ep, head_in, head_odd && paired, 1'b0};
    wire [7:0] flags_view = {4'h0, xfer_done_flag_ff, 1'b0, rx_line_state};
    wire [7:0] rd_mux = hit_cfg ? cfg_ff :
        hit_st ? status_view :
        hit_ctl ? ctl_ff :
        hit_flg ? flags_view : 8'h00;
    // ------------------------------------------------------------
    // Register writes and read capture
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= CFG_RESET;
            ctl_ff <= CTL_RESET;
            prdata_ff <= '0;
        end else begin
            if (wr_cfg) cfg_ff <= pwdata[7:0] & CFG_WMASK;
            if (wr_ctl) ctl_ff <= pwdata[7:0] & (8'h01 << CTL_MODULE_ENABLE);
            // Captured in setup so data stands through the access cycle
            if (rd_now) prdata_ff <= {24'h0, rd_mux};
        end
    end
    // ------------------------------------------------------------
    // Status queue
    // ------------------------------------------------------------
    // A full queue takes no more entries; the engine is answered NAK
    assign sq.push = xfer_done && enabled;
    assign sq.push_data = {xfer_endpoint, xfer_dir_in, xfer_odd};
    assign sq.pop = do_pop;
    assign sq.flush = !enabled;
    status_fifo #(.DEPTH(STATUS_DEPTH), .W(ENTRY_W)) u_queue (
        .pclk(pclk),
        .presetn(presetn),
        .q(sq)
    );
    // ------------------------------------------------------------
    // Transfer done flag
    // ------------------------------------------------------------
    // After a pop the flag waits a short hold-off, so software sees a
    // falling edge even when the next entry is already waiting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_done_flag_ff <= 1'b0;
            reflag_cnt_ff <= '0;
        end else if (!enabled) begin
            xfer_done_flag_ff <= 1'b0;
            reflag_cnt_ff <= '0;
        end else if (do_pop) begin
            xfer_done_flag_ff <= 1'b0;
            reflag_cnt_ff <= 2'(REFLAG_CYCLES - 1);
        end else if (reflag_cnt_ff != '0) begin
            reflag_cnt_ff <= reflag_cnt_ff - 1'b1;
        end else if (!sq.empty) begin
            xfer_done_flag_ff <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Automatic NAK on a full queue
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) auto_nak_ff <= 1'b0;
        else auto_nak_ff <= endpoint_request && sq.full && enabled;
    end
    assign auto_nak = auto_nak_ff;
    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Source chosen before the synchroniser; the selection is static
    // while the module runs, so no glitch crosses.
    wire [2:0] rx_raw = ext_sel ? {sense_plus_in, sense_minus_in, diff_receive_in} :
        {int_sense_plus, int_sense_minus, int_receive};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= rx_raw;
            sync2_ff <= sync1_ff;
        end
    end
    // 00 SE0, 01 low speed, 10 full speed, 11 error
    assign rx_line_state = sync2_ff[2:1];
    assign rx_data = sync2_ff[0];
    // ------------------------------------------------------------
    // Eye pattern sequencer
    // ------------------------------------------------------------
    wire bit_end = (eye_cnt_ff == 8'(EYE_BIT_CYCLES - 1));
    always_comb begin
        nxt_eye = eye_ff;
        case (eye_ff)
            EYE_OFF: if (eye_req) nxt_eye = EYE_FIRST;
            EYE_FIRST: begin
                if (!eye_req) nxt_eye = EYE_OFF;
                else if (bit_end) nxt_eye = EYE_SECOND;
            end
            EYE_SECOND: begin
                if (!eye_req) nxt_eye = EYE_OFF;
                else if (bit_end) nxt_eye = EYE_FIRST;
            end
            default: nxt_eye = EYE_OFF;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eye_ff <= EYE_OFF;
            eye_cnt_ff <= '0;
        end else begin
            eye_ff <= nxt_eye;
            eye_cnt_ff <= (eye_ff == EYE_OFF || bit_end) ? '0 : eye_cnt_ff + 1'b1;
        end
    end
    // Low speed J is diff 0 and full speed K is diff 0, so both
    // sequences open on diff 0 and alternate.
    wire eye_on = (eye_ff != EYE_OFF);
    line_code_t eye_code;
    assign eye_code = (eye_ff == EYE_FIRST) ? LINE_DIFF0 : LINE_DIFF1;
    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    wire sending = enabled && (eye_on || tx_active);
    wire [1:0] code = eye_on ? eye_code : tx_line;
    // Illegal requests fall back to SE0 so both drivers never rise
    wire plus_v = sending && (code == LINE_DIFF1);
    wire minus_v = sending && (code == LINE_DIFF0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_plus_ff <= 1'b0;
            drive_minus_ff <= 1'b0;
            tx_en_n_ff <= 1'b1;
            mon_n_ff <= 1'b1;
        end else begin
            drive_plus_ff <= plus_v;
            drive_minus_ff <= minus_v;
            tx_en_n_ff <= !sending;
            // Monitor shows drive intervals when asked or when external
            mon_n_ff <= !(sending && (cfg_ff[CFG_OE_MONITOR] || ext_sel));
        end
    end
    // Only the selected transceiver is steered; the other stays idle
    assign drive_plus_out = drive_plus_ff && ext_sel;
    assign drive_minus_out = drive_minus_ff && ext_sel;
    assign transmit_enable_n = tx_en_n_ff || !ext_sel;
    assign int_drive_plus = drive_plus_ff && !ext_sel;
    assign int_drive_minus = drive_minus_ff && !ext_sel;
    assign int_transmit_enable_n = tx_en_n_ff || ext_sel;
    assign oe_monitor_n = mon_n_ff;
    // ------------------------------------------------------------
    // Pull-ups and speed
    // ------------------------------------------------------------
    // Pull-ups follow the enable, acting as a soft attach
    wire pull_ok = enabled && pull_req && !ext_sel;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp_pu_ff <= 1'b0;
            dm_pu_ff <= 1'b0;
        end else begin
            dp_pu_ff <= pull_ok && fs_sel;
            dm_pu_ff <= pull_ok && !fs_sel;
        end
    end
    assign dplus_pullup_en = dp_pu_ff;
    assign dminus_pullup_en = dm_pu_ff;
    assign full_speed_edges = fs_sel;
    assign pingpong_mode = pp_field;
    assign module_enabled = enabled;
endmodule

// file: logic/usb_sie_pkg.sv
/*
 * Shared constants and types for the USB line configuration and
 * transfer status block: register offsets, field positions, reset
 * values and line codes.
 * Assumes a 32-bit APB master that addresses aligned words.
 */
package usb_sie_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_LINE_CONFIG = 8'h00;
    localparam logic [7:0] OFS_XFER_STATUS = 8'h04;
    localparam logic [7:0] OFS_USB_CONTROL = 8'h08;
    localparam logic [7:0] OFS_USB_FLAGS = 8'h0c;
    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    localparam int CFG_EYE_TEST = 7;
    localparam int CFG_OE_MONITOR = 6;
    localparam int CFG_PULLUP = 4;
    localparam int CFG_EXT_XCVR = 3;
    localparam int CFG_FULL_SPEED = 2;
    localparam int CFG_PP_HI = 1;
    localparam int CFG_PP_LO = 0;
    localparam logic [7:0] CFG_WMASK = 8'hdf;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ------------------------------------------------------------
    // Control, flag and status fields
    // ------------------------------------------------------------
    localparam int CTL_MODULE_ENABLE = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int FLG_XFER_DONE = 3;
    localparam int ST_ENDP_HI = 6;
    localparam int ST_ENDP_LO = 3;
    localparam int ST_DIR = 2;
    localparam int ST_PINGPONG_POINTER_INDICATOR = 1;
    // ------------------------------------------------------------
    // Timing counts and queue sizes
    // ------------------------------------------------------------
    localparam int REFLAG_CYCLES = 3;
    localparam int STATUS_DEPTH = 4;
    localparam int ENTRY_W = 6;
    // Bus states on the driver pair and sense pair
    typedef enum logic [1:0] {LINE_SE0, LINE_DIFF0, LINE_DIFF1, LINE_ILLEGAL} line_code_t;
    // Ping-pong arrangements
    typedef enum logic [1:0] {PP_NONE, PP_EP0_OUT, PP_ALL, PP_ALL_BUT_EP0} pp_mode_t;
endpackage

// file: testbench/ext_xcvr_model.sv
/*
 * Behavioural off-chip USB transceiver.
 * Assumes the bench sets the host-side bus state while the block listens.
 */
`timescale 1ns/1ps
module ext_xcvr_model (
    input wire logic pclk,
    input wire logic drive_plus_out,
    input wire logic drive_minus_out,
    input wire logic transmit_enable_n,
    input wire logic [1:0] host_state,
    output logic sense_plus_in,
    output logic sense_minus_in,
    output logic diff_receive_in
);
    // ------------------------------
    // Cable levels
    // ------------------------------
    logic [1:0] bus; // {D+, D-} on the cable
    logic noise_ff = 1'b0; // Receiver output is meaningless when lines match
    // Our driver owns the cable only while enabled, else the host does
    assign bus = !transmit_enable_n ? {drive_plus_out, drive_minus_out} : host_state;
    assign sense_plus_in = bus[1];
    assign sense_minus_in = bus[0];
    // One pulse train: D+ over D- reads 1; SE0 or error gives junk
    assign diff_receive_in = (bus == 2'b10) | ((bus[1] == bus[0]) & noise_ff);
    // Junk source toggles each cycle so no stale level passes
    always_ff @(posedge pclk) begin
        noise_ff <= !noise_ff;
    end
endmodule

// file: testbench/tb_usb_sie_config_xcvr_status.sv
/*
 * Self-checking bench for the USB line configuration block.
 * Assumes an APB slave that answers in its first access cycle or later.
 */
`timescale 1ns/1ps
module tb_usb_sie_config_xcvr_status
    import usb_sie_pkg::*;
;
    // ------------------------------
    // Signals
    // ------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, err_v, auto_nak, rx_data, oe_monitor_n, module_enabled;
    logic tx_active = 1'b0, xfer_done = 1'b0, xfer_dir_in = 1'b0, xfer_odd = 1'b0;
    logic endpoint_request = 1'b0;
    logic [1:0] tx_line = 2'h0, host_state = 2'h0, rx_line_state, pingpong_mode;
    logic [3:0] xfer_endpoint = 4'h0;
    logic drive_plus_out, drive_minus_out, transmit_enable_n, sense_plus_in, sense_minus_in;
    logic diff_receive_in, int_drive_plus, int_drive_minus, int_transmit_enable_n;
    logic dplus_pullup_en, dminus_pullup_en, full_speed_edges;
    logic [1:0] eye_s [8]; // Eye pattern samples
    int errors = 0, comparisons = 0, cycles = 0;
    // Status entries {endpoint, dir, odd}; the fifth meets a full queue
    logic [5:0] ents [5] = '{6'h3f, 6'h01, 6'h2e, 6'h29, 6'h0d};
    // Views with field 01: parity kept only on EP0 OUT
    logic [7:0] st_e [4] = '{8'h7c, 8'h02, 8'h5c, 8'h50};
    // ------------------------------
    // Design, transceiver, clock
    // ------------------------------
    usb_sie_config_xcvr_status #(.EYE_BIT_CYCLES(2)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_active, .tx_line,
        .xfer_done, .xfer_endpoint, .xfer_dir_in, .xfer_odd, .endpoint_request, .auto_nak,
        .rx_line_state, .rx_data, .drive_plus_out, .drive_minus_out, .transmit_enable_n,
        .sense_plus_in, .sense_minus_in, .diff_receive_in, .int_drive_plus, .int_drive_minus,
        .int_transmit_enable_n, .int_sense_plus(1'b0), .int_sense_minus(1'b0),
        .int_receive(1'b0), .oe_monitor_n, .dplus_pullup_en, .dminus_pullup_en,
        .full_speed_edges, .pingpong_mode, .module_enabled);
    ext_xcvr_model xcvr (.pclk, .drive_plus_out, .drive_minus_out, .transmit_enable_n,
        .host_state, .sense_plus_in, .sense_minus_in, .diff_receive_in);
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Hang guard: far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    // ------------------------------
    // Tasks
    // ------------------------------
    // One APB transfer; an idle edge follows so psel never toggles twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Speed, transceiver, pull-up change only while disabled
    task automatic setup(input logic [7:0] c);
        apb(1'b1, OFS_USB_CONTROL, 32'h0);
        apb(1'b1, OFS_LINE_CONFIG, {24'h0, c});
        apb(1'b1, OFS_USB_CONTROL, 32'h8);
    endtask
    task automatic txchk(input logic [7:0] c, input logic [2:0] t, input logic [6:0] e);
        setup(c);
        tx_active <= t[2];
        tx_line <= t[1:0];
        repeat (2) @(posedge pclk);
        chk("line pins", e, {drive_plus_out, drive_minus_out, transmit_enable_n, oe_monitor_n,
            int_drive_plus, int_drive_minus, int_transmit_enable_n});
        tx_active <= 1'b0;
    endtask
    // Pull-ups are registered after the enable, so one more edge passes
    task automatic puchk(input logic [7:0] c, input logic [3:0] e);
        setup(c);
        @(posedge pclk);
        chk("pullups", e, {module_enabled, dplus_pullup_en, dminus_pullup_en, full_speed_edges});
    endtask
    task automatic nakchk(input logic e);
        endpoint_request <= 1'b1;
        @(posedge pclk);
        endpoint_request <= 1'b0;
        @(negedge pclk);
        chk("auto nak", e, auto_nak);
        @(posedge pclk);
    endtask
    task automatic flagwait();
        for (int n = 0; n < 4; n++) begin
            apb(1'b0, OFS_USB_FLAGS, 32'h0);
            if (rd_v[FLG_XFER_DONE] === 1'b1) return;
        end
        chk("done flag", 32'h1, rd_v[FLG_XFER_DONE]);
    endtask
    task automatic test_done();
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_LINE_CONFIG, 32'h0);
        chk("config reset", {24'h0, CFG_RESET}, rd_v);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, err_v);
        apb(1'b1, OFS_LINE_CONFIG, 32'hffff_ffff);
        apb(1'b0, OFS_LINE_CONFIG, 32'h0);
        chk("config mask", {24'h0, CFG_WMASK}, rd_v);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_LINE_CONFIG, i);
            chk("pingpong", i, pingpong_mode);
        end
        // Pull-ups: {enable, D+, D-, speed} for FS, LS, external
        puchk(8'h14, 4'hd);
        puchk(8'h10, 4'ha);
        puchk(8'h1c, 4'h9);
        // Driver codes on the external pins, then internal with monitor
        for (int i = 0; i < 4; i++) begin
            txchk(8'h0c, {1'b1, 2'(i)}, (i == 1) ? 7'h21 : (i == 2) ? 7'h41 : 7'h01);
        end
        txchk(8'h0c, 3'h2, 7'h19);
        txchk(8'h04, 3'h6, 7'h1c);
        txchk(8'h44, 3'h6, 7'h14);
        // Sense pair and receive pulse train through the transceiver
        setup(8'h0c);
        for (int s = 0; s < 4; s++) begin
            host_state <= 2'(s);
            repeat (4) @(posedge pclk);
            chk("sense state", s, rx_line_state);
            apb(1'b0, OFS_USB_FLAGS, 32'h0);
            chk("flags sense", s, rd_v[1:0]);
            if (s == 1 || s == 2) chk("receive", s >> 1, rx_data);
        end
        // Status queue: fill past four, NAK when full, pop all
        setup(8'h01);
        nakchk(1'b0);
        for (int i = 0; i < 5; i++) begin
            {xfer_endpoint, xfer_dir_in, xfer_odd} <= ents[i];
            xfer_done <= 1'b1;
            @(posedge pclk);
            xfer_done <= 1'b0;
            @(posedge pclk);
        end
        nakchk(1'b1);
        for (int i = 0; i < 4; i++) begin
            flagwait();
            apb(1'b0, OFS_XFER_STATUS, 32'h0);
            chk("status", {24'h0, st_e[i]}, rd_v);
            apb(1'b1, OFS_USB_FLAGS, 32'h8);
        end
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_USB_FLAGS, 32'h0);
        chk("flag stays clear", 32'h0, rd_v[FLG_XFER_DONE]);
        // Eye pattern: J and K alternate every two cycles
        setup(8'h0c);
        apb(1'b1, OFS_LINE_CONFIG, 32'h8c);
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            @(negedge pclk);
            eye_s[i] = {drive_plus_out, drive_minus_out};
        end
        for (int i = 0; i < 6; i++) chk("eye", {~eye_s[i]}, eye_s[i + 2]);
        chk("eye sending", 32'h0, transmit_enable_n);
        test_done();
    end
endmodule
bind usb_sie_config_xcvr_status usb_sie_config_xcvr_status_properties props (.pclk,
    .presetn, .psel, .penable, .pslverr, .endpoint_request, .auto_nak, .drive_plus_out,
    .drive_minus_out, .transmit_enable_n, .int_drive_plus, .int_drive_minus,
    .int_transmit_enable_n, .oe_monitor_n, .dplus_pullup_en, .dminus_pullup_en,
    .full_speed_edges, .module_enabled);

// file: testbench/usb_sie_config_xcvr_status_properties.sv
/*
 * Port assertions for the USB line configuration block.
 * Assumes one clock pclk and the async active-low reset presetn.
 */
`timescale 1ns/1ps
module usb_sie_config_xcvr_status_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic endpoint_request,
    input wire logic auto_nak,
    input wire logic drive_plus_out,
    input wire logic drive_minus_out,
    input wire logic transmit_enable_n,
    input wire logic int_drive_plus,
    input wire logic int_drive_minus,
    input wire logic int_transmit_enable_n,
    input wire logic oe_monitor_n,
    input wire logic dplus_pullup_en,
    input wire logic dminus_pullup_en,
    input wire logic full_speed_edges,
    input wire logic module_enabled
);
    // ------------------------------
    // Clocking and reset
    // ------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ------------------------------
    // Properties
    // ------------------------------
    no_illegal_a: assert property (!(drive_plus_out && drive_minus_out))
        else $error("external driver pair both high");
    quiet_idle_a: assert property ((drive_plus_out || drive_minus_out) |-> !transmit_enable_n)
        else $error("driver pair active while listening");
    one_path_a: assert property (!(!transmit_enable_n && !int_transmit_enable_n))
        else $error("both transceivers sending");
    monitor_ext_a: assert property (!transmit_enable_n |-> !oe_monitor_n)
        else $error("monitor idle while external sends");
    monitor_cause_a: assert property (!oe_monitor_n |-> !transmit_enable_n || !int_transmit_enable_n)
        else $error("monitor active without sending");
    dplus_speed_a: assert property (dplus_pullup_en |-> $past(full_speed_edges) && $past(module_enabled))
        else $error("D+ pull-up without full speed");
    dminus_speed_a: assert property (dminus_pullup_en |-> !$past(full_speed_edges) && $past(module_enabled))
        else $error("D- pull-up without low speed");
    nak_cause_a: assert property (auto_nak |-> $past(endpoint_request) && $past(module_enabled))
        else $error("automatic NAK without request");
    slverr_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
endmodule
